// ---- pps_defines.svh ----
// constants for the power state sequencer: offsets, fields, resets, timing
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

`define PPS_CLK_HZ        50000000
`define PPS_SLOW_HZ       32768
// core clocks per 32 kHz tick, truncated
`define PPS_TICK_DIV      (`PPS_CLK_HZ / `PPS_SLOW_HZ)
`define PPS_DIV_W         11

// initialization interval, least time, rounded up to 32 kHz ticks
`define PPS_INIT_US       8000
`define PPS_INIT_TICKS    ((`PPS_INIT_US * `PPS_SLOW_HZ + 999999) / 1000000)
`define PPS_TMR_W         16
`define PPS_RST_TICKS     16'h0100
`define PPS_WDOG_TICKS    16'h0400
`define PPS_WAIT_TICKS    16'h0800

// byte addresses of the registers
`define PPS_ADDR_W        5
`define PPS_REG_CTRL      5'h00
`define PPS_REG_BUCK      5'h04
`define PPS_REG_STATUS    5'h08
`define PPS_REG_FLAGS     5'h0c

`define PPS_CTRL_UOFF     0
`define PPS_CTRL_WARM_START_ENABLE   1
`define PPS_CTRL_RESTART  2
`define PPS_CTRL_RST      3'h0
`define PPS_BUCK_UO_LSB   0
`define PPS_BUCK_MH_LSB   8
`define PPS_BUCK_RST      6'h00
`define PPS_FLAG_WARM     0
`define PPS_FLAG_MEMH     1
`define PPS_STAT_PUS_LSB  4
`define PPS_STAT_SUPPLY   8
`define PPS_STAT_KEEP     9

`define PPS_NBUCK         6
`define PPS_NSLOT         7
`define PPS_PUS_W         4
// startup enable masks {ldo group, buck5..buck0} chosen by select pins
`define PPS_PUS_MASK0     7'h7f
`define PPS_PUS_MASK1     7'h3f
`define PPS_PUS_MASK2     7'h7b
`define PPS_PUS_MASK3     7'h1f

`define PPS_RESP_OK       2'h0
`define PPS_RESP_SLVERR   2'h2

`endif

// ---- pps_pkg.sv ----
// types shared by the power state sequencer modules
package pps_pkg;

  typedef enum logic [3:0]
  {
    PPS_COIN,
    PPS_OFF,
    PPS_COLD,
    PPS_WDOG,
    PPS_ON,
    PPS_UOWAIT,
    PPS_USEROFF,
    PPS_MEMHOLD,
    PPS_WARM
  } pps_state_e;

endpackage

// ---- pps_tmr_if.sv ----
// carrier between the sequencer and one of its down-counting timers
`timescale 1ns/1ps
`include "pps_defines.svh"

interface pps_tmr_if;
  logic                    start;
  logic                    tick;
  logic [`PPS_TMR_W-1:0]   load;
  logic                    expired;
  logic                    running;

  modport ctrl (output start, output tick, output load,
                input expired, input running);
  modport tmr  (input start, input tick, input load,
                output expired, output running);
endinterface

// ---- pps_timer.sv ----
// down counter clocked by the 32 kHz tick enable, one expiry pulse
`timescale 1ns/1ps
`include "pps_defines.svh"

module pps_timer
(
  input  wire logic  clk,
  input  wire logic  rst,
  pps_tmr_if.tmr     t
);
  logic [`PPS_TMR_W-1:0] cnt_reg;
  logic                  exp_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (t.start)
      cnt_reg <= t.load;
    else if (t.tick && cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end

  // a restart in the expiry cycle wins, so a stale pulse never leaks out
  always_ff @(posedge clk)
  begin
    if (rst || t.start)
      exp_reg <= 1'b0;
    else
      exp_reg <= t.tick && cnt_reg == `PPS_TMR_W'(1);
  end

  assign t.expired = exp_reg;
  assign t.running = cnt_reg != '0;
endmodule

// ---- pps_top.sv ----
// power state sequencer: state machine, reset pins, regulators, registers
`timescale 1ns/1ps
`include "pps_defines.svh"

// Notes on behaviour
// [RL1] register access honoured only in watchdog, on and user off wait
// [RL2] interrupt output forced low outside watchdog and on
// [RL3] coin cell ignores turn-on, resets low, exits to off on good supply
// [RL4] depleted backup cell in coin cell restores every register default
// [RL5] off starts no timer, resets low, leaves only on a valid turn-on or recovery
// [RL6] off with supply below threshold ignores every turn-on event
// [RL7] cold start from off or memory hold turn-on, recovery or restart
// [RL8] cold start runs init interval, latches select pins, then sequences; 256-tick default reset timer expires before 263-tick init, no slot turns on
// [RL9] cold start holds resets low, reset timer expiry releases to watchdog
// [RL10] keepalive and standby ignored in cold start and watchdog
// [RL11] watchdog drives resets high, its timer expiry moves to on
// [RL12] keepalive low in on goes to off or cold start per configuration
// [RL13] keepalive steers transitions only in the on state
// [RL14] user-off request bit enters user off wait, keepalive then ignored
// [RL15] wait timer expiry goes to user off or memory hold per warm enable
// [RL16] wait expiry clears user-off request as system reset drops
// [RL17] low power off leaves on turn-on only, linear regulators disabled
// [RL18] low power off powers each buck by its own mode bits
// [RL19] startup regulator set chosen by latched select pin levels
// [RL20] coin cell keeps tick divider and supply detection running
// [RL21] user off turn-on enters warm start, expiry to watchdog with flag
// [RL22] memory hold turn-on enters cold start with defaults and flag
// [RL23] user off holds system reset low, processor reset high
// [RL24] memory hold holds both resets low
// [RL25] reset, watchdog and wait durations are 32 kHz tick parameters
module pps_top
#(
  parameter logic [`PPS_TMR_W-1:0] RST_TICKS  = `PPS_RST_TICKS,
  parameter logic [`PPS_TMR_W-1:0] WDOG_TICKS = `PPS_WDOG_TICKS,
  parameter logic [`PPS_TMR_W-1:0] WAIT_TICKS = `PPS_WAIT_TICKS
)
(
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST,
  input  wire logic [`PPS_ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                     AVS_READ,
  input  wire logic                     AVS_WRITE,
  input  wire logic [31:0]              AVS_WRITEDATA,
  input  wire logic [3:0]               AVS_BYTEENABLE,
  output logic      [31:0]              AVS_READDATA,
  output logic      [1:0]               AVS_RESPONSE,
  output logic                          AVS_WAITREQUEST,
  input  wire logic                     MAIN_SUPPLY_SENSE,
  input  wire logic                     BACKUP_CELL_DEPLETED,
  input  wire logic                     TURN_ON_EVENT,
  input  wire logic                     SUPPLY_INTERRUPTION_RECOVERED,
  input  wire logic                     KEEPALIVE_INPUT,
  input  wire logic [`PPS_PUS_W-1:0]    POWER_UP_SELECT_PINS,
  output logic                          SYSTEM_RESET_OUT_N_O,
  output logic                          SYSTEM_RESET_OUT_N_OE,
  output logic                          PROCESSOR_RESET_OUT_N_O,
  output logic                          PROCESSOR_RESET_OUT_N_OE,
  output logic                          INT_OUT,
  output logic [`PPS_NBUCK-1:0]         BUCK_EN,
  output logic                          LDO_EN
);
  localparam int NS = 5;

  pps_pkg::pps_state_e state_reg;
  pps_pkg::pps_state_e state_next;

  // pin synchronisers: stage one is read only by stage two
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  logic [`PPS_PUS_W-1:0] pus1_reg;
  logic [`PPS_PUS_W-1:0] pus2_reg;
  logic          on_prev_reg;
  logic          rec_prev_reg;
  logic          supply_ok;
  logic          depleted;
  logic          turn_on;
  logic          recovered;
  logic          keepalive;

  logic [`PPS_DIV_W-1:0] div_reg;
  logic                  tick_reg;

  logic [2:0]            ctrl_reg;
  logic [`PPS_NBUCK-1:0] uo_mode_reg;
  logic [`PPS_NBUCK-1:0] mh_mode_reg;
  logic [1:0]            flag_reg;
  logic [`PPS_PUS_W-1:0] pus_reg;
  logic [`PPS_NSLOT-1:0] en_reg;
  logic [`PPS_NSLOT-1:0] en_next;
  logic [`PPS_NSLOT-1:0] start_mask;
  logic [2:0]            slot_reg;

  logic        wait_reg;
  logic        ok_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  resp_reg;
  logic        req;
  logic        acc_ok;
  logic        wr_take;
  logic        hit;
  logic        clk_dom_rst;
  logic        load_defaults;
  logic        warm_set;
  logic        memh_set;
  logic        sys_low_reg;
  logic        mcu_low_reg;
  logic        int_reg;

  pps_tmr_if init_t ();
  pps_tmr_if main_t ();

  pps_timer u_init_tmr
  (
    .clk (CORE_CLK),
    .rst (RST),
    .t   (init_t.tmr)
  );

  pps_timer u_main_tmr
  (
    .clk (CORE_CLK),
    .rst (RST),
    .t   (main_t.tmr)
  );

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      pus1_reg     <= '0;
      pus2_reg     <= '0;
      on_prev_reg  <= 1'b0;
      rec_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg    <= {KEEPALIVE_INPUT, SUPPLY_INTERRUPTION_RECOVERED,
                       TURN_ON_EVENT, BACKUP_CELL_DEPLETED,
                       MAIN_SUPPLY_SENSE};
      sync2_reg    <= sync1_reg;
      pus1_reg     <= POWER_UP_SELECT_PINS;
      pus2_reg     <= pus1_reg;
      on_prev_reg  <= sync2_reg[2];
      rec_prev_reg <= sync2_reg[3];
    end
  end

  assign supply_ok = sync2_reg[0];
  assign depleted  = sync2_reg[1];
  assign turn_on   = sync2_reg[2] && !on_prev_reg;
  assign recovered = sync2_reg[3] && !rec_prev_reg;
  assign keepalive = sync2_reg[4];

  // the divider never stops, so coin cell keeps its time base
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || div_reg == `PPS_DIV_W'(`PPS_TICK_DIV - 1))
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1; // RL20
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      tick_reg <= 1'b0;
    else
      tick_reg <= div_reg == `PPS_DIV_W'(`PPS_TICK_DIV - 1);
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pps_pkg::PPS_COIN:
        if (supply_ok)
          state_next = pps_pkg::PPS_OFF; // RL3
      pps_pkg::PPS_OFF:
        if (supply_ok && (turn_on || recovered))
          state_next = pps_pkg::PPS_COLD; // RL5 RL6 RL7
      pps_pkg::PPS_COLD:
        if (main_t.expired)
          state_next = pps_pkg::PPS_WDOG; // RL9 RL10
      pps_pkg::PPS_WDOG:
        if (main_t.expired)
          state_next = pps_pkg::PPS_ON; // RL11 RL10
      pps_pkg::PPS_ON:
        if (!keepalive)
          state_next = ctrl_reg[`PPS_CTRL_RESTART] ?
                       pps_pkg::PPS_COLD : pps_pkg::PPS_OFF; // RL12 RL13
        else if (ctrl_reg[`PPS_CTRL_UOFF])
          state_next = pps_pkg::PPS_UOWAIT; // RL14
      pps_pkg::PPS_UOWAIT:
        if (main_t.expired)
          state_next = ctrl_reg[`PPS_CTRL_WARM_START_ENABLE] ?
                       pps_pkg::PPS_USEROFF : pps_pkg::PPS_MEMHOLD; // RL15
      pps_pkg::PPS_USEROFF:
        if (turn_on)
          state_next = pps_pkg::PPS_WARM; // RL17 RL21
      pps_pkg::PPS_MEMHOLD:
        if (turn_on)
          state_next = pps_pkg::PPS_COLD; // RL17 RL22
      pps_pkg::PPS_WARM:
        if (main_t.expired)
          state_next = pps_pkg::PPS_WDOG; // RL21
      default:
        state_next = pps_pkg::PPS_COIN;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      state_reg <= pps_pkg::PPS_COIN;
    else
      state_reg <= state_next;
  end

  // timers start in the cycle the state changes; off and the low power
  // states load nothing, so no timer is started there
  always_comb
  begin
    main_t.tick  = tick_reg;
    init_t.tick  = tick_reg;
    main_t.start = 1'b0;
    main_t.load  = RST_TICKS;
    init_t.start = 1'b0;
    init_t.load  = `PPS_TMR_W'(`PPS_INIT_TICKS);
    if (state_next != state_reg)
    begin
      case (state_next)
        pps_pkg::PPS_COLD, pps_pkg::PPS_WARM:
        begin
          main_t.start = 1'b1; // RL9 RL25
          init_t.start = 1'b1; // RL8
        end
        pps_pkg::PPS_WDOG:
        begin
          main_t.start = 1'b1; // RL11
          main_t.load  = WDOG_TICKS;
        end
        pps_pkg::PPS_UOWAIT:
        begin
          main_t.start = 1'b1; // RL15
          main_t.load  = WAIT_TICKS;
        end
        default:
          main_t.start = 1'b0; // RL5
      endcase
    end
  end

  assign load_defaults = state_next != state_reg &&
                         (state_next == pps_pkg::PPS_COLD ||
                          state_next == pps_pkg::PPS_WARM); // RL22
  assign clk_dom_rst = RST ||
                       (state_reg == pps_pkg::PPS_COIN && depleted); // RL4

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      pus_reg <= '0;
    else if (init_t.start)
      pus_reg <= pus2_reg; // RL8 RL19
  end

  always_comb
  begin
    case (pus_reg[1:0])
      2'h0:    start_mask = `PPS_PUS_MASK0;
      2'h1:    start_mask = `PPS_PUS_MASK1;
      2'h2:    start_mask = `PPS_PUS_MASK2;
      default: start_mask = `PPS_PUS_MASK3;
    endcase
  end

  // one regulator slot per tick once initialization is over, limiting
  // inrush; bucks kept on through a low power state stay on
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || init_t.start)
      slot_reg <= '0;
    else if (tick_reg && !init_t.running && slot_reg != 3'h7 &&
             (state_reg == pps_pkg::PPS_COLD ||
              state_reg == pps_pkg::PPS_WARM))
      slot_reg <= slot_reg + 1'b1; // RL8
  end

  always_comb
  begin
    en_next = en_reg;
    case (state_reg)
      pps_pkg::PPS_COLD, pps_pkg::PPS_WARM:
        if (tick_reg && !init_t.running && slot_reg != 3'h7)
          en_next = en_reg |
                    (start_mask & (`PPS_NSLOT'(1) << slot_reg)); // RL8 RL19
      pps_pkg::PPS_USEROFF:
        en_next = {1'b0, uo_mode_reg}; // RL17 RL18
      pps_pkg::PPS_MEMHOLD:
        en_next = {1'b0, mh_mode_reg}; // RL17 RL18
      pps_pkg::PPS_COIN, pps_pkg::PPS_OFF:
        en_next = '0;
      default:
        en_next = en_reg;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      en_reg <= '0;
    else
      en_reg <= en_next;
  end

  // open-drain resets: pad level is low whenever enable is high
  always_comb
  begin
    case (state_reg)
      pps_pkg::PPS_WDOG, pps_pkg::PPS_ON, pps_pkg::PPS_UOWAIT:
      begin
        sys_low_reg = 1'b0;
        mcu_low_reg = 1'b0;
      end
      pps_pkg::PPS_USEROFF, pps_pkg::PPS_WARM:
      begin
        sys_low_reg = 1'b1; // RL23
        mcu_low_reg = 1'b0;
      end
      default:
      begin
        sys_low_reg = 1'b1; // RL3 RL5 RL9 RL24
        mcu_low_reg = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      SYSTEM_RESET_OUT_N_OE    <= 1'b1;
      PROCESSOR_RESET_OUT_N_OE <= 1'b1;
    end
    else
    begin
      SYSTEM_RESET_OUT_N_OE    <= sys_low_reg; // RL16
      PROCESSOR_RESET_OUT_N_OE <= mcu_low_reg;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      SYSTEM_RESET_OUT_N_O    <= 1'b0;
      PROCESSOR_RESET_OUT_N_O <= 1'b0;
    end
    else
    begin
      SYSTEM_RESET_OUT_N_O    <= 1'b0;
      PROCESSOR_RESET_OUT_N_O <= 1'b0;
    end
  end

  assign BUCK_EN = en_reg[`PPS_NBUCK-1:0];
  assign LDO_EN  = en_reg[`PPS_NSLOT-1];

  // avalon slave: one wait cycle, then answer with waitrequest low
  assign req     = (AVS_READ || AVS_WRITE) && wait_reg;
  assign acc_ok  = state_reg == pps_pkg::PPS_WDOG ||
                   state_reg == pps_pkg::PPS_ON ||
                   state_reg == pps_pkg::PPS_UOWAIT; // RL1
  assign hit     = AVS_ADDRESS == `PPS_REG_CTRL ||
                   AVS_ADDRESS == `PPS_REG_BUCK ||
                   AVS_ADDRESS == `PPS_REG_STATUS ||
                   AVS_ADDRESS == `PPS_REG_FLAGS;
  assign wr_take = AVS_WRITE && !wait_reg && ok_reg && AVS_BYTEENABLE[0];

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      wait_reg <= 1'b1;
      ok_reg   <= 1'b0;
      resp_reg <= `PPS_RESP_OK;
    end
    else
    begin
      wait_reg <= !req;
      if (req)
      begin
        ok_reg   <= acc_ok && hit; // RL1
        resp_reg <= (acc_ok && hit) ? `PPS_RESP_OK : `PPS_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST || !req || !acc_ok)
      rdata_reg <= '0;
    else
    begin
      case (AVS_ADDRESS)
        `PPS_REG_CTRL:   rdata_reg <= {29'h0, ctrl_reg};
        `PPS_REG_BUCK:   rdata_reg <= {18'h0, mh_mode_reg, 2'h0,
                                       uo_mode_reg};
        `PPS_REG_STATUS: rdata_reg <= {22'h0, keepalive, supply_ok,
                                       pus_reg, state_reg};
        `PPS_REG_FLAGS:  rdata_reg <= {30'h0, flag_reg};
        default:         rdata_reg <= '0;
      endcase
    end
  end

  assign AVS_WAITREQUEST = wait_reg;
  assign AVS_READDATA    = rdata_reg;
  assign AVS_RESPONSE    = resp_reg;

  // general settings fall back to defaults on every start
  always_ff @(posedge CORE_CLK)
  begin
    if (clk_dom_rst || load_defaults)
      ctrl_reg <= `PPS_CTRL_RST; // RL4 RL22
    else if (state_reg == pps_pkg::PPS_UOWAIT && main_t.expired)
      ctrl_reg[`PPS_CTRL_UOFF] <= 1'b0; // RL16
    else if (wr_take && AVS_ADDRESS == `PPS_REG_CTRL)
      ctrl_reg <= AVS_WRITEDATA[2:0];
  end

  // buck mode bits live in the clock domain and survive low power states
  always_ff @(posedge CORE_CLK)
  begin
    if (clk_dom_rst)
    begin
      uo_mode_reg <= `PPS_BUCK_RST; // RL4
      mh_mode_reg <= `PPS_BUCK_RST;
    end
    else if (wr_take && AVS_ADDRESS == `PPS_REG_BUCK)
    begin
      uo_mode_reg <= AVS_WRITEDATA[`PPS_BUCK_UO_LSB +: `PPS_NBUCK];
      mh_mode_reg <= AVS_WRITEDATA[`PPS_BUCK_MH_LSB +: `PPS_NBUCK];
    end
  end

  assign warm_set = state_reg == pps_pkg::PPS_WARM && main_t.expired;
  assign memh_set = state_reg == pps_pkg::PPS_MEMHOLD && turn_on;

  // write one to clear; a set in the same cycle wins over the clear
  always_ff @(posedge CORE_CLK)
  begin
    if (clk_dom_rst)
      flag_reg <= '0; // RL4
    else
    begin
      if (warm_set)
        flag_reg[`PPS_FLAG_WARM] <= 1'b1; // RL21
      else if (wr_take && AVS_ADDRESS == `PPS_REG_FLAGS &&
               AVS_WRITEDATA[`PPS_FLAG_WARM])
        flag_reg[`PPS_FLAG_WARM] <= 1'b0;
      if (memh_set)
        flag_reg[`PPS_FLAG_MEMH] <= 1'b1; // RL22
      else if (wr_take && AVS_ADDRESS == `PPS_REG_FLAGS &&
               AVS_WRITEDATA[`PPS_FLAG_MEMH])
        flag_reg[`PPS_FLAG_MEMH] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      int_reg <= 1'b0;
    else
      int_reg <= (|flag_reg) && (state_reg == pps_pkg::PPS_WDOG ||
                                 state_reg == pps_pkg::PPS_ON); // RL2
  end

  assign INT_OUT = int_reg;
endmodule

// ---- pps_checker.sv ----
// port-level assertions for the power state sequencer
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_checker
(
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic [4:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic [1:0]  AVS_RESPONSE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        SYSTEM_RESET_OUT_N_O,
  input wire logic        SYSTEM_RESET_OUT_N_OE,
  input wire logic        PROCESSOR_RESET_OUT_N_O,
  input wire logic        PROCESSOR_RESET_OUT_N_OE,
  input wire logic        INT_OUT,
  input wire logic        LDO_EN
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  // pin drive lags the state by one cycle, as the grant does
  sequence req_s;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  a_refuse_when_down:
    assert property (req_s ##1 SYSTEM_RESET_OUT_N_OE |->
      !AVS_WAITREQUEST && AVS_RESPONSE == `PPS_RESP_SLVERR)
    else $error("access not refused");
  a_accept_when_up:
    assert property ((req_s and AVS_ADDRESS == `PPS_REG_STATUS)
      ##1 !SYSTEM_RESET_OUT_N_OE |-> AVS_RESPONSE == `PPS_RESP_OK)
    else $error("access refused while running");
  a_answer_one_cycle:
    assert property (req_s |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("answer timing wrong");
  a_refused_reads_zero:
    assert property (!AVS_WAITREQUEST && AVS_RESPONSE ==
      `PPS_RESP_SLVERR |-> AVS_READDATA == 32'h0)
    else $error("refused read carries data");
  a_int_only_up:
    assert property (INT_OUT |-> !SYSTEM_RESET_OUT_N_OE)
    else $error("interrupt high outside running states");
  a_proc_under_sys:
    assert property (PROCESSOR_RESET_OUT_N_OE |-> SYSTEM_RESET_OUT_N_OE)
    else $error("processor reset low alone");
  a_release_both:
    assert property ($fell(PROCESSOR_RESET_OUT_N_OE) |->
      $fell(SYSTEM_RESET_OUT_N_OE) && SYSTEM_RESET_OUT_N_O == 1'b0)
    else $error("resets not released together");
  a_ldo_off_low_power:
    assert property ($rose(SYSTEM_RESET_OUT_N_OE) &&
      !PROCESSOR_RESET_OUT_N_OE |-> ##2 !LDO_EN)
    else $error("linear regulators on in user off");
  c_refused: cover property (!AVS_WAITREQUEST && AVS_RESPONSE[1]);
  c_user_off: cover property (SYSTEM_RESET_OUT_N_OE &&
    !PROCESSOR_RESET_OUT_N_OE);
  c_int: cover property ($rose(INT_OUT));
endmodule

bind pps_top pps_checker u_pps_checker (.CORE_CLK(CORE_CLK), .RST(RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .INT_OUT(INT_OUT), .LDO_EN(LDO_EN),
  .SYSTEM_RESET_OUT_N_O(SYSTEM_RESET_OUT_N_O),
  .SYSTEM_RESET_OUT_N_OE(SYSTEM_RESET_OUT_N_OE),
  .PROCESSOR_RESET_OUT_N_O(PROCESSOR_RESET_OUT_N_O),
  .PROCESSOR_RESET_OUT_N_OE(PROCESSOR_RESET_OUT_N_OE));

// ---- pps_proc_model.sv ----
// processor model: pulled-up reset lines and its keepalive output
`timescale 1ns/1ps
module pps_proc_model
(
  input  wire logic clk,
  input  wire logic sys_oe,
  input  wire logic proc_oe,
  input  wire logic drop,
  output logic      sys_n,
  output logic      proc_n,
  output logic      keepalive = 1'b0
);
  // open drain lines with pull-ups read high once released
  assign sys_n  = !sys_oe;
  assign proc_n = !proc_oe;
  // held high while out of reset; the bench drops it on purpose
  always @(posedge clk)
    keepalive <= proc_n & !drop;
endmodule

// ---- pps_top_tb.sv ----
// self-checking bench for the power state sequencer
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        sup = 1'b0;
  logic        ton = 1'b0;
  logic        rec = 1'b0;
  logic        drop = 1'b0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [1:0]  resp;
  logic [1:0]  r;
  logic        wreq;
  logic        keep;
  logic        sys_oe;
  logic        proc_oe;
  logic        sys_n;
  logic        proc_n;
  logic        int_o;
  logic        ldo;
  logic [5:0]  buck;
  int          mismatches = 0;
  int          comparisons = 0;

  always #10 clk = ~clk;

  pps_top #(.RST_TICKS(16'h0004), .WDOG_TICKS(16'h0004),
    .WAIT_TICKS(16'h0004)) u_pps_top (.CORE_CLK(clk), .RST(rst),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
    .AVS_RESPONSE(resp), .AVS_WAITREQUEST(wreq),
    .MAIN_SUPPLY_SENSE(sup), .BACKUP_CELL_DEPLETED(1'b0),
    .TURN_ON_EVENT(ton), .SUPPLY_INTERRUPTION_RECOVERED(rec),
    .KEEPALIVE_INPUT(keep), .POWER_UP_SELECT_PINS(4'h6),
    .SYSTEM_RESET_OUT_N_O(), .SYSTEM_RESET_OUT_N_OE(sys_oe),
    .PROCESSOR_RESET_OUT_N_O(), .PROCESSOR_RESET_OUT_N_OE(proc_oe),
    .INT_OUT(int_o), .BUCK_EN(buck), .LDO_EN(ldo));

  pps_proc_model u_pps_proc_model (.clk(clk), .sys_oe(sys_oe),
    .proc_oe(proc_oe), .drop(drop), .sys_n(sys_n), .proc_n(proc_n),
    .keepalive(keep));

  task end_of_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task timeout;
    mismatches++;
    $display("wait limit used up at %0t", $time);
    end_of_test;
  endtask

  // request held until the rise that sees waitrequest low; data taken there
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
      timeout;
    q = rdat;
    r = resp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task wait_sys(input logic v);
    int n;
    n = 0;
    while (sys_n !== v && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000)
      timeout;
  endtask

  task wait_state(input logic [3:0] s);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, `PPS_REG_STATUS, 32'h0);
      n++;
    end
    while (q[3:0] !== s && n < 4000);
    if (n >= 4000)
      timeout;
  endtask

  task pulse(input logic on);
    @(posedge clk);
    if (on)
      ton <= 1'b1;
    else
      rec <= 1'b1;
    repeat (6) @(posedge clk);
    ton <= 1'b0;
    rec <= 1'b0;
  endtask

  task t_coin;
    pulse(1'b1);
    repeat (20) @(posedge clk);
    chk(32'({sys_n, proc_n}), 32'h0);
    bus(1'b0, `PPS_REG_STATUS, 32'h0);
    chk(32'(r), 32'(`PPS_RESP_SLVERR));
    chk(q, 32'h0);
    sup <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'({sys_n, proc_n}), 32'h0);
    bus(1'b0, `PPS_REG_STATUS, 32'h0);
    chk(32'(r), 32'(`PPS_RESP_SLVERR));
  endtask

  task t_boot;
    pulse(1'b1);
    bus(1'b0, `PPS_REG_STATUS, 32'h0);
    chk(32'(r), 32'(`PPS_RESP_SLVERR));
    chk(32'({sys_n, proc_n}), 32'h0);
    wait_sys(1'b1);
    chk(32'(proc_n), 32'h1);
    drop <= 1'b1;
    repeat (8) @(posedge clk);
    // watchdog state, pins 6, supply good, keepalive low but ignored
    bus(1'b0, `PPS_REG_STATUS, 32'h0);
    chk(q, 32'h163);
    drop <= 1'b0;
    wait_state(4'h4);
    chk(32'(int_o), 32'h0);
  endtask

  task t_useroff;
    bus(1'b1, `PPS_REG_BUCK, 32'h0205);
    chk(32'(r), 32'(`PPS_RESP_OK));
    bus(1'b1, `PPS_REG_CTRL, 32'h3);
    chk(32'(r), 32'(`PPS_RESP_OK));
    drop <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, `PPS_REG_STATUS, 32'h0);
    chk(32'(q[3:0]), 32'h5);
    wait_sys(1'b0);
    repeat (4) @(posedge clk);
    chk(32'({proc_n, ldo, buck}), 32'h85);
    bus(1'b0, `PPS_REG_CTRL, 32'h0);
    chk(32'(r), 32'(`PPS_RESP_SLVERR));
    drop <= 1'b0;
    pulse(1'b1);
    wait_sys(1'b1);
    repeat (4) @(posedge clk);
    chk(32'(int_o), 32'h1);
    bus(1'b0, `PPS_REG_FLAGS, 32'h0);
    chk(q, 32'h1);
    bus(1'b0, `PPS_REG_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `PPS_REG_FLAGS, 32'h1);
    repeat (4) @(posedge clk);
    chk(32'(int_o), 32'h0);
  endtask

  // warm start disabled: user off wait falls into memory hold
  task t_memhold;
    wait_state(4'h4);
    bus(1'b1, `PPS_REG_CTRL, 32'h1);
    chk(32'(r), 32'(`PPS_RESP_OK));
    wait_sys(1'b0);
    repeat (4) @(posedge clk);
    chk(32'({proc_n, ldo, buck}), 32'h02);
    pulse(1'b1);
    wait_sys(1'b1);
    repeat (4) @(posedge clk);
    bus(1'b0, `PPS_REG_FLAGS, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, `PPS_REG_FLAGS, 32'h2);
  endtask

  task t_keeploss;
    wait_state(4'h4);
    drop <= 1'b1;
    wait_sys(1'b0);
    chk(32'(proc_n), 32'h0);
    bus(1'b0, `PPS_REG_STATUS, 32'h0);
    chk(32'(r), 32'(`PPS_RESP_SLVERR));
    drop <= 1'b0;
  endtask

  task t_recover;
    pulse(1'b0);
    wait_sys(1'b1);
    chk(32'(proc_n), 32'h1);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_coin;
    t_boot;
    t_useroff;
    t_memhold;
    t_keeploss;
    t_recover;
    end_of_test;
  end
endmodule
